// ===== dce_coef_model.sv
`include "dce_defines.svh"
module dce_coef_model import dce_pkg::*; (
   input wire logic clk, // 250 MHz
   input wire logic rst, // async, active high
   input wire logic precision12, // 1: 12-bit samples
   input wire logic restart, // scan or interval start pulse
   input wire logic [7:0] qtab_cfg, // 2 bits per component
   input wire logic [3:0] dc_tab_cfg, // 1 bit per component
   input wire logic [3:0] ac_tab_cfg, // 1 bit per component
   input wire logic samp_valid, // sample offered
   input wire logic [11:0] samp_data, // unsigned sample
   output logic samp_ready, // sample slot free
   output logic shift_valid, // shifted sample offered
   output logic signed [12:0] shift_data, // level-shifted sample
   input wire logic shift_ready, // transform takes sample
   input wire logic coef_valid, // quantized coefficient offered
   input wire logic [14:0] coef_data, // raster-order coefficient
   input wire logic [1:0] coef_comp, // component of block
   output logic coef_ready, // block buffer accepting
   output logic [1:0] qtab_sel, // quantizer table for coef_comp
   output logic sym_valid, // symbol offered
   output logic sym_is_dc, // DC category symbol
   output logic sym_table, // Huffman table number
   output logic [7:0] sym_run_size, // run in high nibble, size low
   output logic [3:0] sym_size, // extra-bit count
   output logic [15:0] sym_bits, // extra bits, right aligned
   input wire logic sym_ready, // packer takes symbol
   output logic marker_pad_req // packer pads and stuffs
);
   localparam logic [5:0] ZZ_POS [64] = '{
      6'h00, 6'h01, 6'h08, 6'h10, 6'h09, 6'h02, 6'h03, 6'h0A,
      6'h11, 6'h18, 6'h20, 6'h19, 6'h12, 6'h0B, 6'h04, 6'h05,
      6'h0C, 6'h13, 6'h1A, 6'h21, 6'h28, 6'h30, 6'h29, 6'h22,
      6'h1B, 6'h14, 6'h0D, 6'h06, 6'h07, 6'h0E, 6'h15, 6'h1C,
      6'h23, 6'h2A, 6'h31, 6'h38, 6'h39, 6'h32, 6'h2B, 6'h24,
      6'h1D, 6'h16, 6'h0F, 6'h17, 6'h1E, 6'h25, 6'h2C, 6'h33,
      6'h3A, 6'h3B, 6'h34, 6'h2D, 6'h26, 6'h1F, 6'h27, 6'h2E,
      6'h35, 6'h3C, 6'h3D, 6'h36, 6'h2F, 6'h37, 6'h3E, 6'h3F};

   dce_state_t s_reg, s_next;
   logic signed [`DCE_DW-1:0] cur;
   logic signed [`DCE_DW-1:0] dc_difference;
   logic [3:0] magnitude_category;
   logic out_free;

   function automatic logic [3:0] mag_cat(input logic signed [15:0] v);
      logic [15:0] a;
      logic [3:0] c;
      a = v[15] ? 16'(-v) : 16'(v);
      c = 4'h0;
      for (int i = 0; i < 15; i++) begin
         if (a[i]) c = 4'(i + 1);
      end
      return c;
   endfunction

   // negative values send low bits of v-1, so the lead bit shows sign
   function automatic logic [15:0] extra(input logic signed [15:0] v, input logic [3:0] c);
      logic [15:0] t;
      t = v[15] ? 16'(v - 16'sh0001) : 16'(v);
      return t & 16'((16'h0001 << c) - 16'h0001);
   endfunction

   always_comb begin
      s_next = s_reg;
      out_free = !s_reg.sym_vld || sym_ready;
      cur = 16'(signed'(s_reg.coef[ZZ_POS[s_reg.idx]]));
      dc_difference = cur - 16'(signed'(s_reg.dc_predictor[s_reg.comp]));
      magnitude_category = s_reg.idx == 6'h00 ? mag_cat(dc_difference) : mag_cat(cur);
      s_next.pad_req = restart;
      s_next.qtab = qtab_cfg[2*coef_comp +: 2];

      if (s_reg.shift_vld && shift_ready) s_next.shift_vld = 1'b0;
      if (samp_valid && s_reg.samp_rdy) begin
         s_next.shift_vld = 1'b1;
         if (precision12)
            s_next.shift_dat = 13'(samp_data) - `DCE_SHIFT12;
         else
            s_next.shift_dat = 13'(samp_data[7:0]) - `DCE_SHIFT8;
      end
      // one-deep slot keeps ready registered at half throughput
      s_next.samp_rdy = !s_next.shift_vld;

      if (s_reg.sym_vld && sym_ready) s_next.sym_vld = 1'b0;

      unique case (s_reg.phase)
         ph_collect: begin
            if (coef_valid && s_reg.coef_rdy) begin
               if (precision12)
                  s_next.coef[s_reg.idx] = coef_data;
               else
                  s_next.coef[s_reg.idx] = 15'(signed'(coef_data[`DCE_CW8-1:0]));
               if (s_reg.idx == 6'h00) s_next.comp = coef_comp;
               s_next.idx = s_reg.idx + 6'h01;
               if (s_reg.idx == `DCE_LAST_K) begin
                  s_next.phase = ph_emit;
                  s_next.run = 6'h00;
               end
            end
         end
         ph_emit: begin
            if (out_free) begin
               s_next.sym_dc = 1'b0;
               s_next.sym_tab = ac_tab_cfg[s_reg.comp];
               if (s_reg.idx == 6'h00) begin
                  s_next.sym_vld = 1'b1;
                  s_next.sym_dc = 1'b1;
                  s_next.sym_tab = dc_tab_cfg[s_reg.comp];
                  s_next.sym_rs = {4'h0, magnitude_category};
                  s_next.sym_size = magnitude_category;
                  s_next.sym_bits = extra(dc_difference, magnitude_category);
                  s_next.dc_predictor[s_reg.comp] = s_reg.coef[0];
                  s_next.idx = 6'h01;
               end else if (cur == 16'sh0000) begin
                  if (s_reg.idx == `DCE_LAST_K) begin
                     s_next.sym_vld = 1'b1;
                     s_next.sym_rs = `DCE_RS_EOB;
                     s_next.sym_size = 4'h0;
                     s_next.sym_bits = 16'h0000;
                     s_next.phase = ph_collect;
                     s_next.idx = 6'h00;
                  end else begin
                     s_next.run = s_reg.run + 6'h01;
                     s_next.idx = s_reg.idx + 6'h01;
                  end
               end else if (s_reg.run >= `DCE_RUN_ZRL) begin
                  // sixteen zeros pending before a nonzero: spend one ZRL
                  s_next.sym_vld = 1'b1;
                  s_next.sym_rs = `DCE_RS_ZRL;
                  s_next.sym_size = 4'h0;
                  s_next.sym_bits = 16'h0000;
                  s_next.run = s_reg.run - `DCE_RUN_ZRL;
               end else begin
                  s_next.sym_vld = 1'b1;
                  s_next.sym_rs = {s_reg.run[3:0], magnitude_category};
                  s_next.sym_size = magnitude_category;
                  s_next.sym_bits = extra(cur, magnitude_category);
                  s_next.run = 6'h00;
                  if (s_reg.idx == `DCE_LAST_K) begin
                     s_next.phase = ph_collect; // last nonzero: no end-of-block
                     s_next.idx = 6'h00;
                  end else begin
                     s_next.idx = s_reg.idx + 6'h01;
                  end
               end
            end
         end
      endcase
      s_next.coef_rdy = s_next.phase == ph_collect;
      // restart wins over a same-cycle DC update
      if (restart) s_next.dc_predictor = '0;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_reg <= '0;
         s_reg.samp_rdy <= 1'b1;
         s_reg.coef_rdy <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign samp_ready = s_reg.samp_rdy;
   assign shift_valid = s_reg.shift_vld;
   assign shift_data = s_reg.shift_dat;
   assign coef_ready = s_reg.coef_rdy;
   assign qtab_sel = s_reg.qtab;
   assign sym_valid = s_reg.sym_vld;
   assign sym_is_dc = s_reg.sym_dc;
   assign sym_table = s_reg.sym_tab;
   assign sym_run_size = s_reg.sym_rs;
   assign sym_size = s_reg.sym_size;
   assign sym_bits = s_reg.sym_bits;
   assign marker_pad_req = s_reg.pad_req;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_shift_eight: assert property (
      samp_valid && samp_ready && !precision12
      |=> shift_valid && shift_data == 13'($past(samp_data[7:0])) - `DCE_SHIFT8)
      else $error("8-bit level shift wrong");
   a_shift_twelve: assert property (
      samp_valid && samp_ready && precision12
      |=> shift_valid && shift_data == 13'($past(samp_data)) - `DCE_SHIFT12)
      else $error("12-bit level shift wrong");
   a_dc_first: assert property (
      s_reg.phase == ph_emit && s_reg.idx == 6'h00 && out_free
      |=> sym_valid && sym_is_dc)
      else $error("block did not open with DC symbol");
   a_dc_predictor_update: assert property (
      s_reg.phase == ph_emit && s_reg.idx == 6'h00 && out_free && !restart
      |=> s_reg.dc_predictor[$past(s_reg.comp)] == $past(s_reg.coef[0]))
      else $error("predictor not updated from DC");
   a_dc_predictor_clear: assert property (
      restart |=> s_reg.dc_predictor == '0)
      else $error("predictors not cleared on restart");
   a_ac_nonzero: assert property (
      sym_valid && !sym_is_dc && sym_run_size != `DCE_RS_EOB && sym_run_size != `DCE_RS_ZRL
      |-> sym_size != 4'h0 && sym_size == sym_run_size[3:0])
      else $error("AC symbol without magnitude");
   a_extra_mask: assert property (
      sym_valid |-> (sym_bits >> sym_size) == 16'h0000)
      else $error("extra bits exceed category");
   a_special_form: assert property (
      sym_valid && !sym_is_dc && (sym_run_size == `DCE_RS_ZRL || sym_run_size == `DCE_RS_EOB)
      |-> sym_size == 4'h0 && sym_bits == 16'h0000)
      else $error("ZRL or end-of-block carries bits");
   a_sym_hold: assert property (
      sym_valid && !sym_ready
      |=> sym_valid && $stable(sym_run_size) && $stable(sym_bits) && $stable(sym_is_dc))
      else $error("symbol changed while stalled");

   // sample path
   a_samp_stall: assert property (
      shift_valid && !shift_ready
      |=> shift_valid && $stable(shift_data))
      else $error("shifted sample changed while stalled");
   a_shift_idle: assert property (
      shift_valid && shift_ready && !(samp_valid && samp_ready)
      |=> !shift_valid)
      else $error("shifted sample offered twice");

   // block collection
   a_coef_narrow: assert property (
      coef_valid && coef_ready && !precision12
      |=> s_reg.coef[$past(s_reg.idx)] == {{4{$past(coef_data[10])}}, $past(coef_data[10:0])})
      else $error("11-bit coefficient not sign extended");
   a_coef_wide: assert property (
      coef_valid && coef_ready && precision12
      |=> s_reg.coef[$past(s_reg.idx)] == $past(coef_data))
      else $error("15-bit coefficient not stored");
   a_qtab_pick: assert property (
      coef_valid
      |=> qtab_sel == $past(qtab_cfg[2*coef_comp +: 2]))
      else $error("wrong quantizer table selected");
   a_comp_latch: assert property (
      coef_valid && coef_ready && s_reg.idx == 6'h00
      |=> s_reg.comp == $past(coef_comp))
      else $error("block component not taken from first term");
   a_emit_entry: assert property (
      coef_valid && coef_ready && s_reg.idx == `DCE_LAST_K
      |=> s_reg.phase == ph_emit && s_reg.idx == 6'h00 && !coef_ready)
      else $error("emission did not start after 64 terms");
   a_dc_predictor_hold: assert property (
      s_reg.phase == ph_collect && !restart
      |=> $stable(s_reg.dc_predictor))
      else $error("predictor moved while collecting");

   // symbol emission
   a_dc_table: assert property (
      s_reg.phase == ph_emit && s_reg.idx == 6'h00 && out_free
      |=> sym_table == $past(dc_tab_cfg[s_reg.comp]))
      else $error("DC symbol on wrong table");
   // comp moves on once the next block starts, so only while emitting
   a_ac_table: assert property (
      s_reg.phase == ph_emit && s_reg.idx != 6'h00 && sym_valid && !sym_is_dc
      |-> sym_table == ac_tab_cfg[s_reg.comp])
      else $error("AC symbol on wrong table");
   a_dc_form: assert property (
      s_reg.phase == ph_emit && s_reg.idx == 6'h00 && out_free
      |=> sym_run_size[7:4] == 4'h0 && sym_size == sym_run_size[3:0])
      else $error("DC symbol carries a run");
   a_zero_bits: assert property (
      sym_valid && sym_size == 4'h0
      |-> sym_bits == 16'h0000)
      else $error("extra bits without category");
   a_dc_sign: assert property (
      s_reg.phase == ph_emit && s_reg.idx == 6'h00 && out_free && dc_difference != 16'sh0000
      |=> sym_bits[sym_size - 4'h1] == !$past(dc_difference[15]))
      else $error("DC extra bits lead with wrong sign");
   a_extra_sign: assert property (
      s_reg.phase == ph_emit && s_reg.idx != 6'h00 && out_free && cur != 16'sh0000 && s_reg.run < `DCE_RUN_ZRL
      |=> sym_bits[sym_size - 4'h1] == !$past(cur[15]))
      else $error("AC extra bits lead with wrong sign");
   a_run_count: assert property (
      s_reg.phase == ph_emit && out_free && s_reg.idx != 6'h00 && s_reg.idx != `DCE_LAST_K && cur == 16'sh0000
      |=> s_reg.run == $past(s_reg.run) + 6'h01)
      else $error("zero run not counted");
   a_zero_silent: assert property (
      s_reg.phase == ph_emit && out_free && s_reg.idx != 6'h00 && s_reg.idx != `DCE_LAST_K && cur == 16'sh0000
      |=> !sym_valid)
      else $error("zero term produced a symbol");
   a_zrl_only: assert property (
      s_reg.phase == ph_emit && out_free && s_reg.idx != 6'h00 && cur != 16'sh0000 && s_reg.run >= `DCE_RUN_ZRL
      |=> sym_valid && sym_run_size == `DCE_RS_ZRL && s_reg.run == $past(s_reg.run) - `DCE_RUN_ZRL)
      else $error("long run not split by ZRL");
   a_eob_last: assert property (
      s_reg.phase == ph_emit && out_free && s_reg.idx == `DCE_LAST_K && cur == 16'sh0000
      |=> sym_valid && !sym_is_dc && sym_run_size == `DCE_RS_EOB && coef_ready)
      else $error("zero tail not closed by end-of-block");

   // handshake and restart
   a_sym_clear: assert property (
      sym_valid && sym_ready && s_reg.phase == ph_collect
      |=> !sym_valid)
      else $error("symbol repeated after acceptance");
   a_pad_pulse: assert property (
      marker_pad_req == $past(restart))
      else $error("pad request not one cycle after restart");

   c_eob: cover property (sym_valid && sym_ready && !sym_is_dc && sym_run_size == `DCE_RS_EOB);
   c_zrl: cover property (sym_valid && sym_ready && sym_run_size == `DCE_RS_ZRL);
   c_restart: cover property (restart ##1 marker_pad_req);
   c_stall: cover property (sym_valid && !sym_ready ##1 sym_valid && sym_ready);
   c_long_run: cover property (sym_valid && sym_ready && !sym_is_dc && sym_run_size[7:4] == 4'hE);
endmodule

// ===== dce_defines.svh
`ifndef DCE_DEFINES_SVH
`define DCE_DEFINES_SVH
// Functional notes
// - 8-bit samples: subtract 128 before transform
// - 12-bit samples: subtract 2048 before transform
// - coefficients 11 or 15 bits, two's complement
// - one of four quantizer tables per component
// - per block: DC table, then AC table
// - emit zig-zag order, DC first, 63 AC
// - DC difference is value minus component predictor
// - predictors zeroed at scan and restart start
// - zero runs coded; end-of-block when rest zero
// - baseline: 8-bit, at most two tables each
// - DC category codes at most 16 bits, never all-ones
// - DC difference falls in one of 12 categories; with precision12 the code uses 16 (up to category 15)
// - append category-count extra bits, msb first
// - negative: low bits of difference minus one
// - F0 means sixteen zeros; zero symbol ends block
// - every FF output byte gets a zero byte
// - pad final byte with ones before markers

`define DCE_NCOEF 64
`define DCE_NCOMP 4
`define DCE_CW 15
`define DCE_CW8 11
`define DCE_DW 16
`define DCE_SW 13
`define DCE_SHIFT8 13'h0080
`define DCE_SHIFT12 13'h0800
`define DCE_LAST_K 6'h3F
`define DCE_RUN_ZRL 6'h10
`define DCE_RS_ZRL 8'hF0
`define DCE_RS_EOB 8'h00
`endif

// ===== dce_far_end.sv
module dce_far_end (
   input wire logic clk, // bench clock
   input wire logic slow, // 1: stall often
   output logic sym_ready, // packer takes symbol
   output logic shift_ready // transform takes sample
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sym_ready = 1'b0;
      shift_ready = 1'b0;
   end
   // ready ignores valid, so offers must stand through stalls
   always @(posedge clk) begin
      #1;
      sym_ready = slow ? ($urandom % 3 == 0) : 1'b1;
      shift_ready = slow ? ($urandom % 2 == 0) : 1'b1;
   end
endmodule

// ===== dce_pkg.sv
`include "dce_defines.svh"
package dce_pkg;
   typedef enum logic {ph_collect, ph_emit} dce_phase_t;

   typedef struct packed {
      dce_phase_t phase;
      logic [`DCE_NCOEF-1:0][`DCE_CW-1:0] coef;
      logic [`DCE_NCOMP-1:0][`DCE_CW-1:0] dc_predictor;
      logic [5:0] idx;
      logic [5:0] run; // up to 62 zeros can pend before the last term
      logic [1:0] comp;
      logic samp_rdy;
      logic shift_vld;
      logic [`DCE_SW-1:0] shift_dat;
      logic coef_rdy;
      logic [1:0] qtab;
      logic sym_vld;
      logic sym_dc;
      logic sym_tab;
      logic [7:0] sym_rs;
      logic [3:0] sym_size;
      logic [`DCE_DW-1:0] sym_bits;
      logic pad_req;
   } dce_state_t;
endpackage

// ===== tb_top.sv
module tb_top;
   import dce_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, precision12 = 0, restart = 0, samp_valid = 0, coef_valid = 0, slow = 0;
   logic [7:0] qtab_cfg = 8'h00;
   logic [3:0] dc_tab_cfg = 4'h0, ac_tab_cfg = 4'h0;
   logic [11:0] samp_data = 12'h000;
   logic [14:0] coef_data = 15'h0000;
   logic [1:0] coef_comp = 2'h0, qtab_sel, last_comp;
   logic samp_ready, shift_valid, shift_ready, coef_ready, sym_valid, sym_is_dc, sym_table;
   logic sym_ready, marker_pad_req, last_cv = 0, last_rst = 0;
   logic signed [12:0] shift_data;
   logic [7:0] sym_run_size;
   logic [3:0] sym_size;
   logic [15:0] sym_bits;
   int num_errors = 0, checks_done = 0, lim, n, r;
   int dc_predictor[4];
   int zz[64];
   logic [29:0] symq[$];
   logic [12:0] sampq[$];

   always #2 clk = ~clk;

   dce_coef_model DUT (.clk, .rst, .precision12, .restart, .qtab_cfg, .dc_tab_cfg, .ac_tab_cfg,
      .samp_valid, .samp_data, .samp_ready, .shift_valid, .shift_data, .shift_ready, .coef_valid,
      .coef_data, .coef_comp, .coef_ready, .qtab_sel, .sym_valid, .sym_is_dc, .sym_table,
      .sym_run_size, .sym_size, .sym_bits, .sym_ready, .marker_pad_req);
   dce_far_end far (.clk, .slow, .sym_ready, .shift_ready);

   task automatic check(input logic [29:0] seen, input logic [29:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   function automatic int cat_of(input int v);
      int a = v < 0 ? -v : v;
      int c = 0;
      while (a > 0) begin
         a >>= 1;
         c++;
      end
      return c;
   endfunction

   function automatic void push_sym(input logic dc, input logic tb, input int run, input int v);
      int c = cat_of(v);
      int x = (v < 0 ? v - 1 : v) & ((1 << c) - 1);
      symq.push_back({dc, tb, 4'(run), 4'(c), 4'(c), 16'(x)});
   endfunction

   always @(posedge clk) begin
      if (sym_valid === 1'b1 && sym_ready === 1'b1)
         check({sym_is_dc, sym_table, sym_run_size, sym_size, sym_bits}, symq.size() ? symq.pop_front() : 30'hX, "sym");
      if (shift_valid === 1'b1 && shift_ready === 1'b1)
         check({17'h0, shift_data}, sampq.size() ? {17'h0, sampq.pop_front()} : 30'hX, "shift");
      if (!rst && last_cv) check(30'(qtab_sel), 30'(qtab_cfg[2*last_comp +: 2]), "qtab");
      if (!rst) check(30'(marker_pad_req), 30'(last_rst), "pad request");
      last_cv <= coef_valid;
      last_comp <= coef_comp;
      last_rst <= restart;
   end

   task automatic send_samples(input int cnt);
      int s;
      samp_valid = 1;
      for (int i = 0; i < cnt; i++) begin
         s = i < 2 ? (i ? 4095 : 0) : $urandom % 4096;
         samp_data = precision12 ? 12'(s) : 12'(s % 256);
         sampq.push_back(precision12 ? 13'(samp_data - 2048) : 13'(samp_data - 128));
         do @(posedge clk); while (samp_ready !== 1'b1);
         #1;
      end
      samp_valid = 0;
   endtask

   task automatic send_block(input logic [1:0] comp, input int mode);
      int v[64];
      int run = 0;
      for (int i = 0; i < 64; i++) begin
         case (mode)
            0: v[i] = ($urandom % 5 == 0) ? int'($urandom % 41) - 20 : 0;
            1: v[i] = (i == 63) ? -lim - 1 : 0;
            default: v[i] = int'($urandom % (2 * lim + 2)) - lim - 1;
         endcase
      end
      push_sym(1'b1, dc_tab_cfg[comp], 0, v[0] - dc_predictor[comp]);
      dc_predictor[comp] = v[0];
      for (int k = 1; k < 64; k++) begin
         if (v[zz[k]] == 0) run++;
         else begin
            for (; run > 15; run -= 16) push_sym(1'b0, ac_tab_cfg[comp], 15, 0);
            push_sym(1'b0, ac_tab_cfg[comp], run, v[zz[k]]);
            run = 0;
         end
      end
      if (run > 0) push_sym(1'b0, ac_tab_cfg[comp], 0, 0);
      coef_comp = comp;
      coef_valid = 1;
      for (int i = 0; i < 64; i++) begin
         coef_data = 15'(v[i]);
         do @(posedge clk); while (coef_ready !== 1'b1);
         #1;
      end
      coef_valid = 0;
      // drain fully so a restart never meets a pending predictor write
      for (int w = 0; w < 2000 && (symq.size() || sampq.size() || coef_ready !== 1'b1); w++) @(posedge clk);
      #1;
      check(30'(symq.size() + sampq.size()), 30'h0, "drain");
   endtask

   initial begin
      #200000;
      num_errors++;
      end_of_test;
   end

   initial begin
      n = 0;
      for (int s = 0; s < 15; s++) begin
         for (int j = 0; j < 8; j++) begin
            r = (s % 2) ? j : 7 - j;
            if (s - r >= 0 && s - r < 8) begin
               zz[n] = r * 8 + s - r;
               n++;
            end
         end
      end
      void'($urandom(32'hEE22));
      repeat (16) @(posedge clk);
      #1 rst = 0;
      for (int t = 0; t < 8; t++) begin
         precision12 = t[0];
         lim = t[0] ? 16383 : 1023;
         {qtab_cfg, dc_tab_cfg, ac_tab_cfg} = 16'($urandom);
         slow = t[1];
         restart = 1;
         dc_predictor = '{default: 0};
         @(posedge clk);
         #1 restart = 0;
         send_samples(6);
         for (int b = 0; b < 6; b++) send_block(2'(b + t), b % 3);
         $display("test %0d done, mismatches %0d", t, num_errors);
      end
      end_of_test;
   end
endmodule
